// File: design/pms_defs.svh
`ifndef PMS_DEFS_SVH
`define PMS_DEFS_SVH
// wake stabilisation figures
`define PMS_CLK_MHZ 100
`define PMS_IRC_RESUME_CYC 4
`define PMS_MOSC_RESUME_CYC 4096
`define PMS_IRC_START_US 60
`define PMS_IRC_START_CYC (`PMS_IRC_START_US * `PMS_CLK_MHZ)
`define PMS_FLASH_START_US 100
`define PMS_FLASH_START_CYC (`PMS_FLASH_START_US * `PMS_CLK_MHZ)
`define PMS_RESET_HOLD_CYC 16
`define PMS_BOOT_ADDR 32'h0000_0000
`define PMS_CNT_W 16
`define PMS_WAKE_W 13
// mode select encodings
`define PMS_MODE_SLEEP 2'h0
`define PMS_MODE_DEEP 2'h1
`define PMS_MODE_PDOWN 2'h2
`endif

// File: design/pms_pkg.sv
`default_nettype none
package pms_pkg;
    typedef enum logic [7:0] {
        PMS_RESET = 8'h01,
        PMS_RUN = 8'h02,
        PMS_SLEEP = 8'h04,
        PMS_DEEP = 8'h08,
        PMS_PDOWN = 8'h10,
        PMS_IRC_START = 8'h20,
        PMS_RESUME = 8'h40,
        PMS_OFF = 8'h80
    } pms_state_type;
endpackage : pms_pkg
`default_nettype wire

// File: design/pms_sequencer.sv
// Functional notes
// - light sleep stops only the core clock; resume re-enables it
// - peripherals run in light sleep; reset or enabled interrupt wakes core
// - light sleep keeps DMA access to peripherals; flash and SRAM off
// - deep sleep stops oscillator and clocks; state kept, pins held
// - deep sleep gates RC oscillator output, keeps it, RTC, flash powered
// - deep sleep powers off PLL and zeroes clock dividers
// - deep sleep ends on reset or any enabled wake source
// - deep wake resumes after 4 cycles on RC, 4096 on main oscillator
// - power-down adds RC oscillator power off and flash power-down
// - power-down stops oscillators, PLLs, resets clock selects and dividers
// - real-time clock and watchdog keep running in power-down
// - power-down wake waits 60 us start-up then four cycles
// - flash wake counter covers 100 us; flash blocked until done
// - deepest power-off entered only by real-time clock request
// - deepest power-off left by any chip reset source (pin, watchdog, power-on, brownout) or alarm match
// - option keeps or removes 32 kHz oscillator power in power-off
// - controller hands mask; collector wakes core on any masked interrupt
// - chip reset from pin, watchdog, power-on or brownout
// - internal reset held until pin released, oscillator up, count, flash ready
// - after reset release core fetches from address zero
// - first brownout threshold raises interrupt and status level
// - second brownout threshold asserts chip reset
// - clock from 12 MHz RC oscillator after power-up and power-down wake
`timescale 1ns/10ps
`default_nettype none
`include "pms_defs.svh"

module pms_sequencer #(
    parameter int WAKE_W = `PMS_WAKE_W,
    parameter int MOSC_RESUME_CYC = `PMS_MOSC_RESUME_CYC,
    parameter int IRC_START_CYC = `PMS_IRC_START_CYC,
    parameter int FLASH_START_CYC = `PMS_FLASH_START_CYC,
    parameter int RESET_HOLD_CYC = `PMS_RESET_HOLD_CYC
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic reset_pin_n,
    input wire logic watchdog_reset,
    input wire logic power_on_detect,
    input wire logic brownout_stage1,
    input wire logic brownout_stage2,
    input wire logic osc_running,
    input wire logic flash_init_done,
    input wire logic wait_for_interrupt,
    input wire logic [1:0] mode_select,
    input wire logic main_osc_selected,
    input wire logic rtc_power_off_request,
    input wire logic rtc_alarm_match,
    input wire logic keep_32k_osc,
    input wire logic [WAKE_W-1:0] interrupt_mask,
    input wire logic [WAKE_W-1:0] wake_sources,
    output logic chip_reset,
    output logic core_reset,
    output logic [31:0] boot_fetch_addr,
    output logic core_clock_en,
    output logic periph_clock_en,
    output logic dma_periph_access,
    output logic flash_sram_en,
    output logic flash_access_en,
    output logic flash_power_down,
    output logic irc_output_en,
    output logic irc_power_en,
    output logic main_osc_en,
    output logic pll_power_en,
    output logic divider_clear,
    output logic clksel_reset,
    output logic pins_hold,
    output logic rtc_osc_power_en,
    output logic watchdog_run_en,
    output logic main_power_en,
    output logic wake_to_core,
    output logic brownout_irq,
    output logic brownout_status
);

    // ==========================================================
    // reset collection
    // ==========================================================
    logic chip_rst;
    assign chip_rst = !reset_pin_n || watchdog_reset || power_on_detect
        || brownout_stage2;

    pms_pkg::pms_state_type state_q, state_d;
    logic [`PMS_CNT_W-1:0] hold_q;
    logic [`PMS_CNT_W-1:0] resume_q;
    logic [`PMS_CNT_W-1:0] irc_q;
    logic [`PMS_CNT_W-1:0] flash_q;
    logic [1:0] mode_q;
    logic main_q;
    logic [WAKE_W-1:0] mask_q;
    logic wake_hit;

    // ==========================================================
    // wake collector
    // ==========================================================
    // mask captured whenever any sleep mode is requested from run, light sleep included
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            mask_q <= '0;
        else if (state_q == pms_pkg::PMS_RUN && wait_for_interrupt)
            mask_q <= interrupt_mask;
    end

    // light sleep uses live mask, stopped modes use captured one
    assign wake_hit = (state_q == pms_pkg::PMS_SLEEP) ?
        |(wake_sources & interrupt_mask) : |(wake_sources & mask_q);

    // ==========================================================
    // main state register
    // ==========================================================
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            state_q <= pms_pkg::PMS_RESET;
        else
            state_q <= state_d;
    end

    // mode and oscillator choice taken at entry
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode_q <= `PMS_MODE_SLEEP;
            main_q <= 1'b0;
        end
        else if (state_q == pms_pkg::PMS_RUN && wait_for_interrupt)
        begin
            mode_q <= mode_select;
            main_q <= main_osc_selected;
        end
        else if (state_q == pms_pkg::PMS_RESET || state_q == pms_pkg::PMS_IRC_START)
            main_q <= 1'b0;
    end

    // next state
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            pms_pkg::PMS_RESET:
                if (!chip_rst && reset_pin_n && osc_running && flash_init_done
                    && hold_q == RESET_HOLD_CYC[`PMS_CNT_W-1:0])
                    state_d = pms_pkg::PMS_RUN;
            pms_pkg::PMS_RUN:
                if (rtc_power_off_request)
                    state_d = pms_pkg::PMS_OFF;
                else if (wait_for_interrupt)
                begin
                    if (mode_select == `PMS_MODE_SLEEP)
                        state_d = pms_pkg::PMS_SLEEP;
                    else if (mode_select == `PMS_MODE_DEEP)
                        state_d = pms_pkg::PMS_DEEP;
                    else
                        state_d = pms_pkg::PMS_PDOWN;
                end
            pms_pkg::PMS_SLEEP:
                if (wake_hit)
                    state_d = pms_pkg::PMS_RUN;
            pms_pkg::PMS_DEEP:
                if (wake_hit)
                    state_d = pms_pkg::PMS_RESUME;
            pms_pkg::PMS_PDOWN:
                if (wake_hit)
                    state_d = pms_pkg::PMS_IRC_START;
            pms_pkg::PMS_IRC_START:
                if (irc_q == IRC_START_CYC[`PMS_CNT_W-1:0])
                    state_d = pms_pkg::PMS_RESUME;
            pms_pkg::PMS_RESUME:
                if (resume_q == 16'h0001)
                    state_d = pms_pkg::PMS_RUN;
            pms_pkg::PMS_OFF:
                if (rtc_alarm_match)
                    state_d = pms_pkg::PMS_RESET;
            default:
                state_d = pms_pkg::PMS_RESET;
        endcase
        if (chip_rst)
            state_d = pms_pkg::PMS_RESET;
    end

    // ==========================================================
    // wake counters
    // ==========================================================
    // fixed reset hold count
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            hold_q <= '0;
        else if (state_q != pms_pkg::PMS_RESET || chip_rst)
            hold_q <= '0;
        else if (hold_q != RESET_HOLD_CYC[`PMS_CNT_W-1:0])
            hold_q <= hold_q + 16'h0001;
    end

    // resume countdown loaded at wake
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            resume_q <= '0;
        else if (state_q == pms_pkg::PMS_DEEP && wake_hit)
            resume_q <= main_q ? MOSC_RESUME_CYC[`PMS_CNT_W-1:0]
                : 16'(`PMS_IRC_RESUME_CYC);
        else if (state_q == pms_pkg::PMS_IRC_START)
            resume_q <= 16'(`PMS_IRC_RESUME_CYC);
        else if (state_q == pms_pkg::PMS_RESUME && resume_q != 16'h0000)
            resume_q <= resume_q - 16'h0001;
    end

    // oscillator start-up counter
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            irc_q <= '0;
        else if (state_q != pms_pkg::PMS_IRC_START)
            irc_q <= '0;
        else
            irc_q <= irc_q + 16'h0001;
    end

    // flash wake counter, restarts on every power-down exit
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            flash_q <= '0;
        else if (state_q == pms_pkg::PMS_PDOWN || state_q == pms_pkg::PMS_OFF)
            flash_q <= '0;
        else if (state_q != pms_pkg::PMS_RESET
            && flash_q != FLASH_START_CYC[`PMS_CNT_W-1:0])
            flash_q <= flash_q + 16'h0001;
    end

    // ==========================================================
    // registered controls
    // ==========================================================
    logic stopped;
    logic pdown;
    assign stopped = state_d == pms_pkg::PMS_DEEP || state_d == pms_pkg::PMS_PDOWN
        || state_d == pms_pkg::PMS_OFF;
    assign pdown = state_d == pms_pkg::PMS_PDOWN || state_d == pms_pkg::PMS_OFF;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            core_clock_en <= 1'b0;
            periph_clock_en <= 1'b0;
            dma_periph_access <= 1'b0;
            flash_sram_en <= 1'b0;
            irc_output_en <= 1'b1;
            irc_power_en <= 1'b1;
            main_osc_en <= 1'b0;
            pll_power_en <= 1'b0;
            divider_clear <= 1'b1;
            clksel_reset <= 1'b1;
            pins_hold <= 1'b0;
            flash_power_down <= 1'b0;
            rtc_osc_power_en <= 1'b1;
            watchdog_run_en <= 1'b1;
            main_power_en <= 1'b1;
            chip_reset <= 1'b1;
            core_reset <= 1'b1;
            boot_fetch_addr <= `PMS_BOOT_ADDR;
        end
        else
        begin
            core_clock_en <= state_d == pms_pkg::PMS_RUN;
            periph_clock_en <= !stopped && state_d != pms_pkg::PMS_RESET;
            dma_periph_access <= state_d == pms_pkg::PMS_RUN
                || state_d == pms_pkg::PMS_SLEEP;
            flash_sram_en <= state_d == pms_pkg::PMS_RUN;
            irc_output_en <= !stopped;
            irc_power_en <= !pdown;
            main_osc_en <= !stopped && main_osc_selected;
            pll_power_en <= !stopped && state_d != pms_pkg::PMS_RESET;
            divider_clear <= stopped || state_d == pms_pkg::PMS_RESET;
            clksel_reset <= pdown || state_d == pms_pkg::PMS_RESET;
            pins_hold <= stopped;
            flash_power_down <= pdown;
            rtc_osc_power_en <= state_d != pms_pkg::PMS_OFF || keep_32k_osc;
            watchdog_run_en <= state_d != pms_pkg::PMS_OFF;
            main_power_en <= state_d != pms_pkg::PMS_OFF;
            chip_reset <= chip_rst;
            core_reset <= state_d == pms_pkg::PMS_RESET || state_d == pms_pkg::PMS_OFF;
            boot_fetch_addr <= `PMS_BOOT_ADDR;
        end
    end

    // flash access gated by wake counter
    assign flash_access_en = flash_sram_en
        && flash_q == FLASH_START_CYC[`PMS_CNT_W-1:0];
    assign wake_to_core = wake_hit && state_q != pms_pkg::PMS_RUN;

    // brownout first stage is a level to controller and status
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            brownout_irq <= 1'b0;
            brownout_status <= 1'b0;
        end
        else
        begin
            brownout_irq <= brownout_stage1;
            brownout_status <= brownout_stage1;
        end
    end

    // ==========================================================
    // assertions
    // ==========================================================
    AST_SLEEP_CORE_ONLY: assert property (@(posedge clock) disable iff (!reset_n)
        state_q == pms_pkg::PMS_SLEEP |-> !core_clock_en && periph_clock_en)
        else $error("sleep clocks wrong");
    AST_SLEEP_WAKE: assert property (@(posedge clock) disable iff (!reset_n)
        state_q == pms_pkg::PMS_SLEEP && wake_hit && !chip_rst |=> core_clock_en)
        else $error("sleep wake missed");
    AST_DEEP_GATES: assert property (@(posedge clock) disable iff (!reset_n)
        state_q == pms_pkg::PMS_DEEP |-> !pll_power_en && divider_clear && irc_power_en)
        else $error("deep sleep gating wrong");
    AST_DEEP_IRC_RESUME: assert property (@(posedge clock) disable iff (!reset_n)
        state_q == pms_pkg::PMS_DEEP && wake_hit && !main_q && !chip_rst
        |=> !core_clock_en [*4] ##1 core_clock_en)
        else $error("irc resume count wrong");
    AST_PDOWN_FLASH: assert property (@(posedge clock) disable iff (!reset_n)
        state_q == pms_pkg::PMS_PDOWN |-> flash_power_down && !irc_power_en)
        else $error("power-down flash wrong");
    AST_FLASH_BLOCK: assert property (@(posedge clock) disable iff (!reset_n)
        flash_access_en |-> flash_q == FLASH_START_CYC[`PMS_CNT_W-1:0])
        else $error("flash accessed early");
    AST_OFF_ENTRY: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(state_q == pms_pkg::PMS_OFF) |-> $past(rtc_power_off_request))
        else $error("off without rtc request");
    AST_CHIP_RESET: assert property (@(posedge clock) disable iff (!reset_n)
        !reset_pin_n |=> chip_reset && core_reset)
        else $error("reset not raised");
    AST_OFF_32K: assert property (@(posedge clock) disable iff (!reset_n)
        state_q == pms_pkg::PMS_OFF |-> rtc_osc_power_en == $past(keep_32k_osc))
        else $error("32k option wrong");
    AST_DEEP_MODE_TAKEN: assert property (@(posedge clock) disable iff (!reset_n)
        state_q == pms_pkg::PMS_DEEP |-> mode_q == `PMS_MODE_DEEP)
        else $error("deep sleep without deep mode select");

endmodule : pms_sequencer

`default_nettype wire

// File: dv/pms_core_model.sv
`timescale 1ns/10ps
`default_nettype none

// =====================================================
// core and interrupt controller stand-in
module pms_core_model #(
    parameter int WAKE_W = 13
) (
    input wire logic clock,
    input wire logic core_clock_en,
    output logic wait_for_interrupt,
    output logic [1:0] mode_select,
    output logic [WAKE_W-1:0] interrupt_mask,
    output logic [WAKE_W-1:0] wake_sources
);
    // idle core: no request, nothing pending
    initial
    begin
        wait_for_interrupt = 1'b0;
        mode_select = 2'h0;
        interrupt_mask = '0;
        wake_sources = '0;
    end

    // mode and mask settle before the one-cycle wfi pulse, sent once running or after 50 cycles
    task automatic sleep_req(input logic [1:0] mode, input logic [WAKE_W-1:0] mask);
        int n;
        @(negedge clock);
        mode_select = mode;
        interrupt_mask = mask;
        for (n = 0; n < 50 && core_clock_en !== 1'b1; n++)
            @(negedge clock);
        wait_for_interrupt = 1'b1;
        @(negedge clock);
        wait_for_interrupt = 1'b0;
        repeat (3) @(negedge clock);
    endtask : sleep_req

    // pending interrupt levels, changed on the falling edge
    task automatic set_pending(input logic [WAKE_W-1:0] v);
        wake_sources = v;
    endtask : set_pending
endmodule : pms_core_model

`default_nettype wire

// File: dv/pms_sequencer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "pms_defs.svh"

// =====================================================
// sequencer testbench
module pms_sequencer_tb_top;
    localparam int MOSC = 16;
    localparam int IRCS = 20;
    localparam int HOLD = 4;
    logic clock, reset_n, reset_pin_n, watchdog_reset, power_on_detect, brownout_stage1;
    logic brownout_stage2, osc_running, flash_init_done, main_osc_selected, keep_32k_osc;
    logic rtc_power_off_request, rtc_alarm_match, wait_for_interrupt;
    logic [1:0] mode_select;
    logic [12:0] interrupt_mask, wake_sources;
    logic chip_reset, core_reset, core_clock_en, periph_clock_en, dma_periph_access;
    logic flash_sram_en, flash_access_en, flash_power_down, irc_output_en, irc_power_en;
    logic main_osc_en, pll_power_en, divider_clear, clksel_reset, pins_hold, rtc_osc_power_en;
    logic watchdog_run_en, main_power_en, wake_to_core, brownout_irq, brownout_status;
    logic [31:0] boot_fetch_addr;
    int err_total = 0;
    int checks = 0;

    // design with shortened waits
    pms_sequencer #(.MOSC_RESUME_CYC(MOSC), .IRC_START_CYC(IRCS), .FLASH_START_CYC(30),
        .RESET_HOLD_CYC(HOLD)) DUT (
        .clock(clock), .reset_n(reset_n), .reset_pin_n(reset_pin_n),
        .watchdog_reset(watchdog_reset), .power_on_detect(power_on_detect),
        .brownout_stage1(brownout_stage1), .brownout_stage2(brownout_stage2),
        .osc_running(osc_running), .flash_init_done(flash_init_done),
        .wait_for_interrupt(wait_for_interrupt), .mode_select(mode_select),
        .main_osc_selected(main_osc_selected), .rtc_power_off_request(rtc_power_off_request),
        .rtc_alarm_match(rtc_alarm_match), .keep_32k_osc(keep_32k_osc),
        .interrupt_mask(interrupt_mask), .wake_sources(wake_sources),
        .chip_reset(chip_reset), .core_reset(core_reset), .boot_fetch_addr(boot_fetch_addr),
        .core_clock_en(core_clock_en), .periph_clock_en(periph_clock_en),
        .dma_periph_access(dma_periph_access), .flash_sram_en(flash_sram_en),
        .flash_access_en(flash_access_en), .flash_power_down(flash_power_down),
        .irc_output_en(irc_output_en), .irc_power_en(irc_power_en), .main_osc_en(main_osc_en),
        .pll_power_en(pll_power_en), .divider_clear(divider_clear),
        .clksel_reset(clksel_reset), .pins_hold(pins_hold),
        .rtc_osc_power_en(rtc_osc_power_en), .watchdog_run_en(watchdog_run_en),
        .main_power_en(main_power_en), .wake_to_core(wake_to_core),
        .brownout_irq(brownout_irq), .brownout_status(brownout_status)
    );

    // far side: core and interrupt controller
    pms_core_model core (
        .clock(clock), .core_clock_en(core_clock_en), .wait_for_interrupt(wait_for_interrupt),
        .mode_select(mode_select), .interrupt_mask(interrupt_mask),
        .wake_sources(wake_sources)
    );

    // 100 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // =====================================================
    // checking helpers
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    function automatic logic watch(input int which);
        case (which)
            0: return core_clock_en;
            1: return flash_access_en;
            default: return !core_reset;
        endcase
    endfunction : watch

    // count rising edges until the watched output is high, bounded
    task automatic wait_for(input int which, input int lim, output int n);
        n = 0;
        while (n < lim && watch(which) !== 1'b1)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        if (watch(which) === 1'b1)
            @(negedge clock);
        else
        begin
            err_total++;
            $display("BAD wait on output %0d expected 1 seen 0", which);
            end_of_test;
        end
    endtask : wait_for

    // unmasked sources must not wake; a masked one wakes within lo..hi edges
    task automatic wake(input int b, input int lo, input int hi);
        int n;
        core.set_pending(~(13'h0001 << b));
        repeat (6) @(negedge clock);
        check("core clock with unmasked source", core_clock_en, 1'b0);
        check("wake request on unmasked source", wake_to_core, 1'b0);
        core.set_pending(13'h1FFF);
        #1;
        check("wake request on masked source", wake_to_core, 1'b1);
        wait_for(0, 5000, n);
        check("wake delay in range", n >= lo && n <= hi, 1'b1);
        core.set_pending(13'h0000);
    endtask : wake

    // =====================================================
    // scenarios
    task automatic t_reset_release;
        int n;
        repeat (20) @(negedge clock);
        check("core reset before flash ready", core_reset, 1'b1);
        flash_init_done = 1'b1;
        wait_for(2, 50, n);
        check("boot fetch address", boot_fetch_addr, `PMS_BOOT_ADDR);
        check("rc oscillator output after power-up", irc_output_en, 1'b1);
    endtask : t_reset_release

    task automatic t_sleep;
        core.sleep_req(`PMS_MODE_SLEEP, 13'h0002);
        check("core clock in sleep", core_clock_en, 1'b0);
        check("peripheral clock in sleep", periph_clock_en, 1'b1);
        check("dma access in sleep", dma_periph_access, 1'b1);
        check("flash and sram in sleep", flash_sram_en, 1'b0);
        wake(1, 1, 3);
    endtask : t_sleep

    // every wake source once; the last entry runs from the main oscillator
    task automatic t_deep;
        int c;
        for (int i = 0; i < 13; i++)
        begin
            main_osc_selected = (i == 12);
            c = (i == 12) ? MOSC : `PMS_IRC_RESUME_CYC;
            core.sleep_req(`PMS_MODE_DEEP, 13'h0001 << i);
            check("peripheral clock in deep sleep", periph_clock_en, 1'b0);
            check("pins held in deep sleep", pins_hold, 1'b1);
            check("rc output in deep sleep", irc_output_en, 1'b0);
            check("rc power in deep sleep", irc_power_en, 1'b1);
            check("rtc osc in deep sleep", rtc_osc_power_en, 1'b1);
            check("flash power in deep sleep", flash_power_down, 1'b0);
            check("pll power in deep sleep", pll_power_en, 1'b0);
            check("divider clear in deep sleep", divider_clear, 1'b1);
            check("main power in deep sleep", main_power_en, 1'b1);
            wake(i, c + 1, c + 4);
            main_osc_selected = 1'b0;
        end
    endtask : t_deep

    task automatic t_pdown;
        int n;
        for (int m = 2; m < 4; m++)
        begin
            core.sleep_req(m[1:0], 13'h0400);
            check("rc power in power-down", irc_power_en, 1'b0);
            check("flash power-down", flash_power_down, 1'b1);
            check("main osc in power-down", main_osc_en, 1'b0);
            check("clock select reset", clksel_reset, 1'b1);
            check("divider clear in power-down", divider_clear, 1'b1);
            check("rtc osc in power-down", rtc_osc_power_en, 1'b1);
            check("watchdog in power-down", watchdog_run_en, 1'b1);
            wake(10, IRCS + 5, IRCS + 8);
            check("flash blocked after wake", flash_access_en, 1'b0);
            check("rc output after wake", irc_output_en, 1'b1);
            wait_for(1, 40, n);
        end
    endtask : t_pdown

    // deepest off with 32 kHz oscillator removed, then kept
    task automatic t_off;
        int n;
        for (int k = 0; k < 2; k++)
        begin
            keep_32k_osc = k[0];
            rtc_power_off_request = 1'b1;
            @(negedge clock);
            rtc_power_off_request = 1'b0;
            repeat (3) @(negedge clock);
            check("main power in off", main_power_en, 1'b0);
            check("32 kHz osc power in off", rtc_osc_power_en, k[0]);
            core.set_pending(13'h1FFF);
            repeat (6) @(negedge clock);
            check("off kept with interrupts", main_power_en, 1'b0);
            core.set_pending(13'h0000);
            rtc_alarm_match = 1'b1;
            @(negedge clock);
            rtc_alarm_match = 1'b0;
            wait_for(0, 500, n);
            check("main power after alarm", main_power_en, 1'b1);
        end
    endtask : t_off

    // brownout interrupt, then each chip reset source in turn
    task automatic t_sources;
        int n;
        brownout_stage1 = 1'b1;
        repeat (2) @(negedge clock);
        check("brownout irq", brownout_irq, 1'b1);
        check("brownout status", brownout_status, 1'b1);
        check("no reset on first threshold", chip_reset, 1'b0);
        brownout_stage1 = 1'b0;
        for (int s = 0; s < 4; s++)
        begin
            reset_pin_n = (s != 0);
            watchdog_reset = (s == 1);
            power_on_detect = (s == 2);
            brownout_stage2 = (s == 3);
            repeat (3) @(negedge clock);
            check("chip reset from source", chip_reset, 1'b1);
            check("core reset from source", core_reset, 1'b1);
            reset_pin_n = 1'b1;
            watchdog_reset = 1'b0;
            power_on_detect = 1'b0;
            brownout_stage2 = 1'b0;
            wait_for(2, 40, n);
            check("reset hold count", n >= HOLD + 1 && n <= HOLD + 4, 1'b1);
        end
    endtask : t_sources

    // main sequence
    initial
    begin
        reset_n = 1'b0;
        reset_pin_n = 1'b1;
        {watchdog_reset, power_on_detect, brownout_stage1, brownout_stage2} = 4'h0;
        {flash_init_done, main_osc_selected, keep_32k_osc} = 3'h0;
        {rtc_power_off_request, rtc_alarm_match} = 2'h0;
        osc_running = 1'b1;
        repeat (16) @(negedge clock);
        reset_n = 1'b1;
        t_reset_release();
        t_sleep();
        t_deep();
        t_pdown();
        t_off();
        t_sources();
        end_of_test();
    end

    // overall hang limit
    initial
    begin
        #500000;
        err_total++;
        end_of_test();
    end
endmodule : pms_sequencer_tb_top

`default_nettype wire
